// File: otu_defines.vh
/*
 * Constants of the oscillator training unit: command periods, window
 * length, error counter limits and training thresholds.
 * Assumes a 200 MHz ref_clk; included by bare name.
 */
`ifndef OTU_DEFINES_VH
`define OTU_DEFINES_VH

// Clock rate and measurement window
`define OTU_CLK_MHZ        200
`define OTU_WINDOW_US      4000
`define OTU_NOMINAL_CYCLES (`OTU_WINDOW_US * `OTU_CLK_MHZ)

// Command-response period codes and their lengths in microseconds
`define OTU_CMD_P500       2'h0
`define OTU_CMD_P1000      2'h1
`define OTU_CMD_P2000      2'h2
`define OTU_CMD_P4000      2'h3

// Periodic-collection period codes, all accepted
`define OTU_PER_P500       3'h0
`define OTU_PER_P666       3'h1
`define OTU_PER_P1000      3'h2
`define OTU_PER_P1333      3'h3
`define OTU_PER_P2000      3'h4
`define OTU_PER_P4000      3'h5

// Error filter limits
`define OTU_ERR_FLAG       7'h40
`define OTU_ERR_MAX        7'h7f
`define OTU_ERR_MIN        7'h00

// Training defaults, in reference cycles, trim codes and microseconds
`define OTU_WIN_CYCLES     32'd16000
`define OTU_ADJ_CYCLES     32'd800
`define OTU_TRIM_FACTORY   8'h80
`define OTU_TRIM_STEP      8'h01
`define OTU_BLOCK_US       100

`endif

// File: otu_sync.v
/*
 * Three-flop synchroniser for one pin-level input; a change is passed on
 * once the second and third flops agree.
 * Assumes ref_clk and a synchronous active-high reset.
 */
module otu_sync (
	input  wire ref_clk,
	input  wire srst,
	input  wire din,
	output reg  dout
);
	reg s1;
	reg s2;
	reg s3;

	// Shift chain; dout follows only on agreement
	always @(posedge ref_clk) begin
		if (srst) begin
			s1   <= 1'b0;
			s2   <= 1'b0;
			s3   <= 1'b0;
			dout <= 1'b0;
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3)
				dout <= s3;
		end
	end
endmodule // otu_sync

// File: otu_period_decode.v
/*
 * Turns the programmed command period into the number of command periods
 * per measurement window, and reports whether the code may be trained on.
 * Pure combinational; inputs are stable configuration bits.
 */
`include "otu_defines.vh"
module otu_period_decode (
	input  wire       periodic_mode,
	input  wire [1:0] command_period_field,
	input  wire [2:0] periodic_period_field,
	output reg  [3:0] periods_per_window,
	output reg        period_ok
);
	// Periods that fit in the window, per mode and code
	always @* begin
		periods_per_window = 4'h8;
		period_ok          = 1'b1;
		if (periodic_mode) begin
			case (periodic_period_field)
				`OTU_PER_P500:   periods_per_window = 4'h8;
				`OTU_PER_P666:   periods_per_window = 4'h6;
				`OTU_PER_P1000:  periods_per_window = 4'h4;
				`OTU_PER_P1333:  periods_per_window = 4'h3;
				`OTU_PER_P2000:  periods_per_window = 4'h2;
				`OTU_PER_P4000:  periods_per_window = 4'h1;
				default:         periods_per_window = 4'h1;
			endcase
		end else begin
			case (command_period_field)
				`OTU_CMD_P500:  periods_per_window = 4'h8;
				`OTU_CMD_P1000: periods_per_window = 4'h4;
				`OTU_CMD_P2000: periods_per_window = 4'h2;
				`OTU_CMD_P4000: periods_per_window = 4'h1;
				default: begin
					periods_per_window = 4'h1;
					period_ok          = 1'b0;
				end
			endcase
		end
	end
endmodule // otu_period_decode

// File: otu_train.v
/*
 * Oscillator training unit. Measures reference cycles across a 4 ms
 * window of master command periods, steps the oscillator trim code, and
 * filters window results into a training-failure flag.
 * Assumes command_strobe is a pin-level pulse at each command start and
 * command_block_end a same-clock pulse at the end of command blocking.
 * The strobe passes a three-flop filter, so a pulse must stand for at
 * least two ref_clk cycles to be seen; every start is seen four edges
 * late, and that constant delay cancels out of the measured count.
 * A strobe that arrives before the blocking end of the closing command
 * is not counted, so command periods must outlast the blocking time.
 * Configuration inputs are expected to change only while training is off.
 * The cycle counter saturates in ST_COUNT but not in ST_APPLY, so a master
 * stalled before its closing strobe never wraps a count back into the training window.
 */
`include "otu_defines.vh"
module otu_train #(
	parameter [31:0] NOMINAL_CYCLES = `OTU_NOMINAL_CYCLES,
	parameter [31:0] WIN_CYCLES     = `OTU_WIN_CYCLES,
	parameter [31:0] ADJ_CYCLES     = `OTU_ADJ_CYCLES,
	parameter [7:0]  TRIM_FACTORY   = `OTU_TRIM_FACTORY,
	parameter [7:0]  TRIM_STEP      = `OTU_TRIM_STEP
) (
	input  wire       ref_clk,
	input  wire       srst,
	input  wire       train_enable_bit,
	input  wire       train_revert_bit,
	input  wire       periodic_mode,
	input  wire [1:0] command_period_field,
	input  wire [2:0] periodic_period_field,
	input  wire       command_strobe,
	input  wire       command_block_end,
	output reg  [7:0] osc_trim,
	output reg        train_fail_flag,
	output reg  [6:0] error_count,
	output reg [31:0] measured_cycle_count
);
	// States of the measurement sequencer
	localparam [1:0] ST_IDLE  = 2'h0;
	localparam [1:0] ST_ARM   = 2'h1;
	localparam [1:0] ST_COUNT = 2'h2;
	localparam [1:0] ST_APPLY = 2'h3;

	wire        strobe_sync;
	reg         strobe_prev;
	wire        strobe_rise;
	wire [3:0]  periods_per_window;
	wire        period_ok;
	wire        train_ok;
	reg  [1:0]  state;
	reg  [31:0] cycle_count;
	reg  [3:0]  period_count;
	reg         started;
	reg         in_window;
	reg  [7:0]  next_trim;
	reg  [6:0]  next_error_count;
	reg  [1:0]  next_state;
	reg  [31:0] next_cycle_count;
	reg  [3:0]  next_period_count;
	reg  [31:0] next_measured;
	reg         next_started;
	wire        window_close;
	wire        apply_now;
	wire        revert_now;
	wire        period_fault;
	wire        filter_fault;

	// Command strobe from the bus pin
	otu_sync u_sync (
		.ref_clk (ref_clk),
		.srst    (srst),
		.din     (command_strobe),
		.dout    (strobe_sync)
	);

	// Window length in command periods for the active mode
	otu_period_decode u_dec (
		.periodic_mode         (periodic_mode),
		.command_period_field  (command_period_field),
		.periodic_period_field (periodic_period_field),
		.periods_per_window    (periods_per_window),
		.period_ok             (period_ok)
	);

	// Edge of the synchronised strobe
	always @(posedge ref_clk) begin
		if (srst)
			strobe_prev <= 1'b0;
		else
			strobe_prev <= strobe_sync;
	end
	assign strobe_rise = strobe_sync & ~strobe_prev;

	// Training allowed in this mode with this period
	assign train_ok = train_enable_bit & (periodic_mode | period_ok);

	// True when value plus margin still falls short of target
	function below_by;
		input [31:0] value;
		input [31:0] target;
		input [31:0] margin;
		below_by = ({1'b0, value} + {1'b0, margin}) < {1'b0, target};
	endfunction

	// True when value lies beyond target plus margin
	function above_by;
		input [31:0] value;
		input [31:0] target;
		input [31:0] margin;
		above_by = {1'b0, value} > ({1'b0, target} + {1'b0, margin});
	endfunction

	// Saturating up/down step of the error filter
	function [6:0] err_step;
		input [6:0] count;
		input       count_up;
		if (count_up && count != `OTU_ERR_MAX)
			err_step = count + 7'h01;
		else if (!count_up && count != `OTU_ERR_MIN)
			err_step = count - 7'h01;
		else
			err_step = count;
	endfunction

	// Window judgement, next trim and next filter value
	always @* begin
		in_window = !below_by(measured_cycle_count, NOMINAL_CYCLES,
			WIN_CYCLES) && !above_by(measured_cycle_count,
			NOMINAL_CYCLES, WIN_CYCLES);
		next_trim = osc_trim;
		if (above_by(measured_cycle_count, NOMINAL_CYCLES, ADJ_CYCLES))
			next_trim = osc_trim - TRIM_STEP;
		else if (below_by(measured_cycle_count, NOMINAL_CYCLES,
				ADJ_CYCLES))
			next_trim = osc_trim + TRIM_STEP;
		next_error_count = err_step(error_count, ~in_window);
	end

	// Closing strobe, blocking end and revert events
	assign window_close = strobe_rise &&
		(period_count + 4'h1 >= periods_per_window);
	assign apply_now    = (state == ST_APPLY) && command_block_end &&
		train_ok;
	assign revert_now   = !train_enable_bit && started && train_revert_bit;

	// Next state and counters of the measurement sequencer
	always @* begin
		next_state        = state;
		next_cycle_count  = cycle_count;
		next_period_count = period_count;
		next_measured     = measured_cycle_count;
		next_started      = started;
		if (!train_ok) begin
			next_state        = ST_IDLE;
			next_cycle_count  = 32'h0000_0000;
			next_period_count = 4'h0;
			if (revert_now)
				next_started = 1'b0;
		end else begin
			case (state)
				ST_IDLE: begin
					next_state = ST_ARM;
				end
				ST_ARM: begin
					if (strobe_rise) begin
						next_state        = ST_COUNT;
						next_cycle_count  = 32'h0000_0001;
						next_period_count = 4'h0;
						next_started      = 1'b1;
					end
				end
				ST_COUNT: begin
					// Saturate so a stalled master cannot wrap the count
					if (cycle_count != 32'hffff_ffff)
						next_cycle_count = cycle_count + 32'h0000_0001;
					if (strobe_rise)
						next_period_count = period_count + 4'h1;
					if (window_close) begin
						next_measured = cycle_count;
						next_state    = ST_APPLY;
					end
				end
				ST_APPLY: begin
					// Next window already runs from the closing strobe
					next_cycle_count  = cycle_count + 32'h0000_0001;
					next_period_count = 4'h0;
					if (command_block_end) begin
						// Keep the cycles seen since the closing strobe
						next_cycle_count = cycle_count -
							measured_cycle_count + 32'h0000_0001;
						next_state       = ST_COUNT;
					end
				end
				default: begin
					next_state = ST_IDLE;
				end
			endcase
		end
	end

	// Sequencer registers
	always @(posedge ref_clk) begin
		if (srst) begin
			state                <= ST_IDLE;
			cycle_count          <= 32'h0000_0000;
			period_count         <= 4'h0;
			measured_cycle_count <= 32'h0000_0000;
			started              <= 1'b0;
		end else begin
			state                <= next_state;
			cycle_count          <= next_cycle_count;
			period_count         <= next_period_count;
			measured_cycle_count <= next_measured;
			started              <= next_started;
		end
	end

	// Trim register: steps at blocking end, factory value on revert
	always @(posedge ref_clk) begin
		if (srst)
			osc_trim <= TRIM_FACTORY;
		else if (revert_now)
			osc_trim <= TRIM_FACTORY;
		else if (apply_now && in_window)
			osc_trim <= next_trim;
	end // Holds otherwise

	// Error filter: one step per judged window
	always @(posedge ref_clk) begin
		if (srst)
			error_count <= `OTU_ERR_MIN;
		else if (apply_now)
			error_count <= next_error_count;
	end

	// Failure causes: unusable command period, or filter at or above OTU_ERR_FLAG
	assign period_fault = train_enable_bit & ~periodic_mode &
		~period_ok;
	assign filter_fault = train_enable_bit &
		(error_count >= `OTU_ERR_FLAG);

	// Failure flag from period check or error filter
	always @(posedge ref_clk) begin
		if (srst)
			train_fail_flag <= 1'b0;
		else
			train_fail_flag <= period_fault | filter_fault;
	end
endmodule // otu_train

// File: otu_train_assertions.sv
/* Port checker for otu_train, bound to each instance.
 * Assumes one clock, ref_clk, with synchronous srst. */
module otu_train_assertions #(parameter [7:0] TRIM_FACTORY = 8'h80) (
	input logic        ref_clk,
	input logic        srst,
	input logic        train_enable_bit,
	input logic        train_revert_bit,
	input logic        command_block_end,
	input logic [7:0]  osc_trim,
	input logic        train_fail_flag,
	input logic [6:0]  error_count,
	input logic [31:0] measured_cycle_count
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	// Reset state, trim moves, revert and the error filter
	a_reset_clears: assert property ($fell(srst) |->
		osc_trim == TRIM_FACTORY && error_count == 7'h00 && !train_fail_flag
		&& measured_cycle_count == 32'h0) else $error("reset state");
	a_trim_cause: assert property ($changed(osc_trim)
		&& !$past(srst) && $past(train_enable_bit) |-> $past(command_block_end)
		|| $past(command_block_end, 2)) else $error("trim unprompted");
	a_trim_unit: assert property ($changed(osc_trim)
		&& !$past(srst) && $past(train_enable_bit) |->
		osc_trim - $past(osc_trim) + 8'h01 <= 8'h02) else $error("trim step");
	a_revert_factory: assert property ((!train_enable_bit
		&& train_revert_bit) [*3] |-> osc_trim == TRIM_FACTORY)
		else $error("no revert");
	a_hold_trim: assert property ((!train_enable_bit
		&& !train_revert_bit) [*2] |=> $stable(osc_trim))
		else $error("trim not held");
	a_flag_level: assert property (($stable(error_count)
		&& $stable(train_enable_bit)) [*2] |-> train_fail_flag ==
		(train_enable_bit && error_count >= 7'h40)) else $error("flag level");
	a_err_step: assert property ($changed(error_count)
		&& !$past(srst) |-> error_count - $past(error_count) + 8'h01 <= 8'h02)
		else $error("error step");
	a_err_cause: assert property ($changed(error_count)
		&& !$past(srst) |-> $past(command_block_end)
		|| $past(command_block_end, 2)) else $error("error unprompted");
	// Main scenarios
	c_trim_up: cover property (osc_trim > $past(osc_trim));
	c_trim_down: cover property (osc_trim < $past(osc_trim));
	c_flag_rise: cover property ($rose(train_fail_flag));
endmodule // otu_train_assertions
bind otu_train otu_train_assertions #(.TRIM_FACTORY(TRIM_FACTORY))
	i_otu_train_assertions (.*);

// File: otu_master.sv
/* Command master model: start pulses p cycles apart and an
 * end-of-blocking pulse in each period. The bench calls send. */
module otu_master (
	input  logic ref_clk,
	output logic command_strobe = 1'b0,
	output logic command_block_end = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	// Keeps the programmed command period; pin idles low afterwards
	task send(input integer n, input integer p);
		integer i;
		for (i = 0; i < n * p; i = i + 1) begin
			@(posedge ref_clk);
			command_strobe <= (i % p < 2);
			command_block_end <= (i % p == 10);
		end
	endtask
endmodule // otu_master

// File: otu_train_test.sv
/* Self-checking bench for otu_train against an integer model.
 * Nominal window shortened to 200 cycles; otu_master sends commands. */
module otu_train_test;
	timeunit 1ns;
	timeprecision 1ps;
	reg         ref_clk = 1'b0, srst = 1'b1, periodic_mode = 1'b0;
	reg         train_enable_bit = 1'b0, train_revert_bit = 1'b0;
	reg  [1:0]  command_period_field = 2'h0;
	reg  [2:0]  periodic_period_field = 3'h0;
	wire        command_strobe, command_block_end, train_fail_flag;
	wire [7:0]  osc_trim;
	wire [6:0]  error_count;
	wire [31:0] measured_cycle_count;
	integer     errors = 0, checks = 0, seed = 42194, t = 128, e = 0;
	integer     i, n, pd_n [0:7] = '{8, 6, 4, 3, 2, 1, 1, 1};
	reg  [31:0] k;
	// 200 MHz clock
	always #2.5 ref_clk = ~ref_clk;
	otu_train #(.NOMINAL_CYCLES(32'd200), .WIN_CYCLES(32'd41),
		.ADJ_CYCLES(32'd5)) i_otu_train (.*);
	otu_master i_otu_master (.ref_clk(ref_clk),
		.command_strobe(command_strobe), .command_block_end(command_block_end));
	// Compares one value and counts it
	task check(input [31:0] seen, input [31:0] exp);
		checks = checks + 1;
		if (seen !== exp) begin
			errors = errors + 1;
			$display("wrong value at %0t: %h, expected %h", $time, seen, exp);
		end
	endtask
	// One window of n periods of p cycles, then model update and compare
	task window(input integer p);
		integer m;
		m = n * p;
		@(posedge ref_clk);
		train_enable_bit <= 1'b1;
		repeat (2) @(posedge ref_clk);
		i_otu_master.send(n + 1, p);
		repeat (2) @(posedge ref_clk);
		if (m <= 241 && m >= 159) begin
			t = t - (m > 205) + (m < 195);
			e = (e > 0) ? e - 1 : 0;
		end else
			e = (e < 127) ? e + 1 : 127;
		check(osc_trim, t);
		check(error_count, e);
		check(train_fail_flag, e >= 64);
		check(measured_cycle_count, m);
		train_enable_bit <= 1'b0;
		repeat (3) @(posedge ref_clk);
	endtask
	// Reset, random windows, trim steps, revert, error ramp
	initial begin
		repeat (8) @(posedge ref_clk);
		srst <= 1'b0;
		check(osc_trim, t);
		for (i = 0; i < 12; i = i + 1) begin
			k = $random(seed);
			periodic_mode <= k[8];
			command_period_field <= k[1:0];
			periodic_period_field <= k[6:4];
			n = k[8] ? pd_n[k[6:4]] : 8 >> k[1:0];
			window(2 * (100 / n + k[14:12] - 4));
		end
		$display("random windows done");
		periodic_mode <= 1'b0;
		command_period_field <= 2'h2;
		n = 2;
		window(96);
		window(104);
		train_revert_bit <= 1'b1;
		repeat (4) @(posedge ref_clk);
		t = 128;
		check(osc_trim, t);
		train_revert_bit <= 1'b0;
		$display("trim steps and revert done");
		command_period_field <= 2'h3;
		n = 1;
		for (i = 0; i < 66; i = i + 1)
			window(i < 65 ? 300 : 200);
		$display("error filter done");
		end_of_test;
	end
	// Cuts a hang short after the expected run length
	initial begin
		repeat (100000) @(posedge ref_clk);
		errors = errors + 1;
		end_of_test;
	end
	// Prints the counts and the verdict, then stops
	task end_of_test;
		$display("checks %0d, errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
endmodule // otu_train_test
